/* design/sad_top.sv */
`timescale 1ns/1ps
module sad_top (
    input wire logic aclk,                    // Clock, 40 MHz
    input wire logic aresetn,                 // Synchronous reset, active low
    input wire logic req_valid,               // Access request strobe
    input wire logic [33:0] req_addr,         // Access address
    input wire logic req_io,                  // I/O cycle
    input wire logic req_write,               // Write cycle
    input wire logic req_from_hub,            // Issued by a hub port
    input wire logic req_smm_code,            // SMM code fetch
    input wire logic req_dword,               // Double-word write
    input wire logic [31:0] req_data,         // Write data
    output logic route_valid,                 // Decoded result strobe
    output sad_pkg::sad_dest_t route_dest,    // Decoded destination
    output logic msg_valid,                   // Interrupt message to processor bus
    output logic [33:0] msg_addr,             // Interrupt message address
    output logic [31:0] msg_data,             // Interrupt message data
    output logic target_ready,                // Decoder completes message transaction
    input wire logic [31:0] s_axi_awaddr,     // Write address
    input wire logic s_axi_awvalid,           // Write address valid
    output logic s_axi_awready,               // Write address ready
    input wire logic [31:0] s_axi_wdata,      // Write data
    input wire logic [3:0] s_axi_wstrb,       // Write strobes
    input wire logic s_axi_wvalid,            // Write data valid
    output logic s_axi_wready,                // Write data ready
    output logic [1:0] s_axi_bresp,           // Write response
    output logic s_axi_bvalid,                // Write response valid
    input wire logic s_axi_bready,            // Write response ready
    input wire logic [31:0] s_axi_araddr,     // Read address
    input wire logic s_axi_arvalid,           // Read address valid
    output logic s_axi_arready,               // Read address ready
    output logic [31:0] s_axi_rdata,          // Read data
    output logic [1:0] s_axi_rresp,           // Read response
    output logic s_axi_rvalid,                // Read valid
    input wire logic s_axi_rready             // Read ready
);
    logic [31:0] ctrl_reg, low_top_reg, shadow_lo_reg, shadow_hi_reg;
    logic [31:0] b_win_reg, b_pref_reg, c_win_reg, c_pref_reg, query_reg;
    logic [31:0] rdata_next;
    logic [31:0] awaddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg, w_held_reg, rd_err;
    logic wr_fire;
    sad_pkg::sad_dest_t req_dest, query_dest;

    ////////////////////////////////////////////////////////////////////////
    // Decode of live requests and of the software query register
    sad_route u_live (
        .addr(req_addr),
        .is_io(req_io),
        .is_write(req_write),
        .from_hub(req_from_hub),
        .smm_code(req_smm_code),
        .is_dword(req_dword),
        .ctrl(ctrl_reg),
        .low_top(low_top_reg),
        .shadow_lo(shadow_lo_reg),
        .shadow_hi(shadow_hi_reg),
        .b_win(b_win_reg),
        .b_pref(b_pref_reg),
        .c_win(c_win_reg),
        .c_pref(c_pref_reg),
        .dest(req_dest)
    );

    sad_route u_query (
        .addr({query_reg[sad_pkg::Q_ADDR_HI +: 7], 7'h00, query_reg[sad_pkg::Q_ADDR_LO +: 20]}),
        .is_io(query_reg[sad_pkg::Q_IO]),
        .is_write(query_reg[sad_pkg::Q_WRITE]),
        .from_hub(query_reg[sad_pkg::Q_SRC_HUB]),
        .smm_code(query_reg[sad_pkg::Q_CODE]),
        .is_dword(query_reg[sad_pkg::Q_DWORD]),
        .ctrl(ctrl_reg),
        .low_top(low_top_reg),
        .shadow_lo(shadow_lo_reg),
        .shadow_hi(shadow_hi_reg),
        .b_win(b_win_reg),
        .b_pref(b_pref_reg),
        .c_win(c_win_reg),
        .c_pref(c_pref_reg),
        .dest(query_dest)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered route result, one cycle after the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_valid <= 1'b0;
            route_dest <= sad_pkg::SAD_DST_PORT_A;
        end else begin
            route_valid <= req_valid;
            if (req_valid) begin
                route_dest <= req_dest;
            end
        end
    end

    // message forwarded with its data, never to DRAM
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_valid <= 1'b0;
            msg_addr <= 34'h0_0000_0000;
            msg_data <= 32'h0000_0000;
        end else begin
            msg_valid <= req_valid && (req_dest == sad_pkg::SAD_DST_IRQ_MSG);
            if (req_valid && (req_dest == sad_pkg::SAD_DST_IRQ_MSG)) begin
                msg_addr <= req_addr;
                msg_data <= req_data;
            end
        end
    end

    // decoder itself signals target ready for the message
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_ready <= 1'b0;
        end else begin
            target_ready <= msg_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_reg[7:0] <= sad_pkg::REG_QUERY && awaddr_reg[31:8] == 24'h00_0000)
                           ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] sad_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : sad_merge

    // software keeps only one routing enable; the lowest port wins otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= sad_pkg::CTRL_RESET;
            low_top_reg <= sad_pkg::LOW_TOP_RESET;
            shadow_lo_reg <= sad_pkg::SHADOW_RESET;
            shadow_hi_reg <= sad_pkg::SHADOW_RESET;
            b_win_reg <= sad_pkg::WIN_RESET;
            b_pref_reg <= sad_pkg::WIN_RESET;
            c_win_reg <= sad_pkg::WIN_RESET;
            c_pref_reg <= sad_pkg::WIN_RESET;
            query_reg <= 32'h0000_0000;
        end else if (wr_fire && awaddr_reg[31:8] == 24'h00_0000) begin
            case (awaddr_reg[7:0])
                sad_pkg::REG_CTRL: ctrl_reg <= sad_merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_007F;
                sad_pkg::REG_LOW_TOP: low_top_reg <= sad_merge(low_top_reg, wdata_reg, wstrb_reg);
                sad_pkg::REG_SHADOW_LO: shadow_lo_reg <= sad_merge(shadow_lo_reg, wdata_reg, wstrb_reg);
                sad_pkg::REG_SHADOW_HI: shadow_hi_reg <= sad_merge(shadow_hi_reg, wdata_reg, wstrb_reg)
                                                         & 32'h0000_03FF;
                sad_pkg::REG_B_WIN: b_win_reg <= sad_merge(b_win_reg, wdata_reg, wstrb_reg);
                sad_pkg::REG_B_PREF: b_pref_reg <= sad_merge(b_pref_reg, wdata_reg, wstrb_reg);
                sad_pkg::REG_C_WIN: c_win_reg <= sad_merge(c_win_reg, wdata_reg, wstrb_reg);
                sad_pkg::REG_C_PREF: c_pref_reg <= sad_merge(c_pref_reg, wdata_reg, wstrb_reg);
                sad_pkg::REG_QUERY: query_reg <= sad_merge(query_reg, wdata_reg, wstrb_reg);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one read at a time
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rdata_next = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr[31:8] != 24'h00_0000) begin
            rd_err = 1'b1;
        end else begin
            case (s_axi_araddr[7:0])
                sad_pkg::REG_CTRL: rdata_next = ctrl_reg;
                sad_pkg::REG_LOW_TOP: rdata_next = low_top_reg;
                sad_pkg::REG_SHADOW_LO: rdata_next = shadow_lo_reg;
                sad_pkg::REG_SHADOW_HI: rdata_next = shadow_hi_reg;
                sad_pkg::REG_B_WIN: rdata_next = b_win_reg;
                sad_pkg::REG_B_PREF: rdata_next = b_pref_reg;
                sad_pkg::REG_C_WIN: rdata_next = c_win_reg;
                sad_pkg::REG_C_PREF: rdata_next = c_pref_reg;
                sad_pkg::REG_QUERY: rdata_next = query_reg;
                sad_pkg::REG_RESULT: rdata_next = {29'h0000_0000, query_dest};
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rd_err ? 2'b10 : 2'b00;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // 34-bit memory and 17-bit I/O addresses cover the full spaces
    // relied on from software; not checked
endmodule : sad_top

/* design/sad_pkg.sv */
package sad_pkg;
    // Destinations of a decoded access
    typedef enum logic [2:0] {
        SAD_DST_DRAM,
        SAD_DST_PORT_A,
        SAD_DST_PORT_B,
        SAD_DST_PORT_C,
        SAD_DST_PORT_D,
        SAD_DST_IRQ_MSG
    } sad_dest_t;

    localparam int ADDR_W = 34;
    localparam int IO_ADDR_W = 17;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LOW_TOP = 8'h04;
    localparam logic [7:0] REG_SHADOW_LO = 8'h08;
    localparam logic [7:0] REG_SHADOW_HI = 8'h0C;
    localparam logic [7:0] REG_B_WIN = 8'h10;
    localparam logic [7:0] REG_B_PREF = 8'h14;
    localparam logic [7:0] REG_C_WIN = 8'h18;
    localparam logic [7:0] REG_C_PREF = 8'h1C;
    localparam logic [7:0] REG_QUERY = 8'h20;
    localparam logic [7:0] REG_RESULT = 8'h24;

    // Control register fields
    localparam int CTRL_VGA_B = 0;
    localparam int CTRL_VGA_C = 1;
    localparam int CTRL_VGA_D = 2;
    localparam int CTRL_MONO = 3;
    localparam int CTRL_SMM_EN = 4;
    localparam int CTRL_SMM_OPEN = 5;
    localparam int CTRL_ISA_HOLE = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] LOW_TOP_RESET = 32'h0000_0000;
    localparam logic [31:0] SHADOW_RESET = 32'h0000_0000;
    // Window registers: limit in [27:16], base in [11:0], 1 MB units
    localparam logic [31:0] WIN_RESET = 32'h0000_FFFF;
    // Query register fields
    localparam int Q_ADDR_LO = 0;
    localparam int Q_SRC_HUB = 20;
    localparam int Q_WRITE = 21;
    localparam int Q_IO = 22;
    localparam int Q_CODE = 23;
    localparam int Q_DWORD = 24;
    localparam int Q_ADDR_HI = 25;

    // Fixed address map, byte addresses
    localparam logic [33:0] VGA_A_LO = 34'h0_000A_0000;
    localparam logic [33:0] VGA_B_HI = 34'h0_000B_FFFF;
    localparam logic [33:0] MONO_LO = 34'h0_000B_0000;
    localparam logic [33:0] MONO_HI = 34'h0_000B_7FFF;
    localparam logic [33:0] SHADOW_LO = 34'h0_000C_0000;
    localparam logic [33:0] EXP_HI = 34'h0_000D_FFFF;
    localparam logic [33:0] EXT_HI = 34'h0_000E_FFFF;
    localparam logic [33:0] SHADOW_HI = 34'h0_000F_FFFF;
    localparam logic [33:0] ISA_HOLE_LO = 34'h0_00F0_0000;
    localparam logic [33:0] ISA_HOLE_HI = 34'h0_00FF_FFFF;
    localparam logic [33:0] IOAPIC_A_LO = 34'h0_FEC0_0000;
    localparam logic [33:0] IOAPIC_A_HI = 34'h0_FEC7_FFFF;
    localparam logic [33:0] IOAPIC_B_LO = 34'h0_FEC8_0000;
    localparam logic [33:0] IOAPIC_B_HI = 34'h0_FEC8_0FFF;
    localparam logic [33:0] IOAPIC_C_LO = 34'h0_FEC8_1000;
    localparam logic [33:0] IOAPIC_C_HI = 34'h0_FEC8_1FFF;
    localparam logic [33:0] IOAPIC_D_LO = 34'h0_FEC8_2000;
    localparam logic [33:0] IOAPIC_D_HI = 34'h0_FEC8_2FFF;
    localparam logic [33:0] MSG_LO = 34'h0_FEE0_0000;
    localparam logic [33:0] MSG_HI = 34'h0_FEEF_FFFF;
    localparam logic [33:0] ONE_MB = 34'h0_0010_0000;
    localparam logic [33:0] FOUR_GB = 34'h1_0000_0000;
    localparam int SEG16K_SHIFT = 14;

    // Monochrome adapter I/O ports
    localparam logic [16:0] MONO_IO_0 = 17'h0_03B4;
    localparam logic [16:0] MONO_IO_1 = 17'h0_03B5;
    localparam logic [16:0] MONO_IO_2 = 17'h0_03B8;
    localparam logic [16:0] MONO_IO_3 = 17'h0_03B9;
    localparam logic [16:0] MONO_IO_4 = 17'h0_03BA;
    localparam logic [16:0] MONO_IO_5 = 17'h0_03BF;
endpackage : sad_pkg

/* design/sad_route.sv */
`timescale 1ns/1ps
// Combinational destination decode for one access
module sad_route (
    input wire logic [33:0] addr,             // Memory or I/O address
    input wire logic is_io,                   // I/O cycle
    input wire logic is_write,                // Write cycle
    input wire logic from_hub,                // Issued by a hub port
    input wire logic smm_code,                // Processor SMM code fetch
    input wire logic is_dword,                // Double-word write
    input wire logic [31:0] ctrl,             // Control register
    input wire logic [31:0] low_top,          // Low memory top, byte address [31:0]
    input wire logic [31:0] shadow_lo,        // Expansion segment attributes
    input wire logic [31:0] shadow_hi,        // Extended and system BIOS attributes
    input wire logic [31:0] b_win,            // Port B window
    input wire logic [31:0] b_pref,           // Port B prefetch window
    input wire logic [31:0] c_win,            // Port C window
    input wire logic [31:0] c_pref,           // Port C prefetch window
    output sad_pkg::sad_dest_t dest           // Destination
);
    logic [33:0] low_top_full;
    logic [11:0] mb;
    logic in_vga, in_mono, in_shadow, in_hole_range;
    logic [1:0] attr;
    logic [3:0] seg;
    logic vga_smm;

    assign low_top_full = {2'b00, low_top};
    assign mb = addr[31:20];
    assign in_vga = (addr >= sad_pkg::VGA_A_LO) && (addr <= sad_pkg::VGA_B_HI);
    assign in_mono = (addr >= sad_pkg::MONO_LO) && (addr <= sad_pkg::MONO_HI);
    assign in_shadow = (addr >= sad_pkg::SHADOW_LO) && (addr <= sad_pkg::SHADOW_HI);
    assign in_hole_range = (addr >= low_top_full) && (addr >= sad_pkg::ONE_MB) && (addr < sad_pkg::FOUR_GB);
    assign seg = 4'(addr[19:sad_pkg::SEG16K_SHIFT] - 6'h30);
    assign vga_smm = ctrl[sad_pkg::CTRL_SMM_EN] && (ctrl[sad_pkg::CTRL_SMM_OPEN] || smm_code);

    // Attribute bits per segment: bit 0 read to DRAM, bit 1 write to DRAM
    always_comb begin
        attr = 2'b00;
        if (seg < 4'h8) begin
            attr = shadow_lo[{seg[2:0], 1'b0} +: 2];
        end else if (seg < 4'hC) begin
            attr = shadow_hi[{seg[1:0], 1'b0} +: 2];
        end else begin
            attr = shadow_hi[9:8];
        end
    end

    // one destination, fixed and legacy first
    always_comb begin
        dest = sad_pkg::SAD_DST_PORT_A;
        if (is_io) begin
            if (ctrl[sad_pkg::CTRL_MONO] && (addr[16:0] == sad_pkg::MONO_IO_0 || addr[16:0] == sad_pkg::MONO_IO_1 ||
                addr[16:0] == sad_pkg::MONO_IO_2 || addr[16:0] == sad_pkg::MONO_IO_3 ||
                addr[16:0] == sad_pkg::MONO_IO_4 || addr[16:0] == sad_pkg::MONO_IO_5)) begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end else begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end
        end else if (in_vga) begin
            if (vga_smm) begin
                dest = sad_pkg::SAD_DST_DRAM;
            end else if (in_mono && ctrl[sad_pkg::CTRL_MONO]) begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end else if (ctrl[sad_pkg::CTRL_VGA_B]) begin
                dest = sad_pkg::SAD_DST_PORT_B;
            end else if (ctrl[sad_pkg::CTRL_VGA_C]) begin
                dest = sad_pkg::SAD_DST_PORT_C;
            end else if (ctrl[sad_pkg::CTRL_VGA_D]) begin
                dest = sad_pkg::SAD_DST_PORT_D;
            end else begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end
        end else if (in_shadow) begin
            if (from_hub) begin
                dest = sad_pkg::SAD_DST_DRAM;
            end else if (is_write ? attr[1] : attr[0]) begin
                dest = sad_pkg::SAD_DST_DRAM;
            end else begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end
        end else if (ctrl[sad_pkg::CTRL_ISA_HOLE] && addr >= sad_pkg::ISA_HOLE_LO &&
                     addr <= sad_pkg::ISA_HOLE_HI) begin
            dest = sad_pkg::SAD_DST_PORT_A;
        // DRAM below the low top and above 4 GB
        end else if (!in_hole_range) begin
            dest = sad_pkg::SAD_DST_DRAM;
        end else begin
            if (!from_hub && addr >= sad_pkg::IOAPIC_A_LO && addr <= sad_pkg::IOAPIC_A_HI) begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end else if (!from_hub && addr >= sad_pkg::IOAPIC_B_LO && addr <= sad_pkg::IOAPIC_B_HI) begin
                dest = sad_pkg::SAD_DST_PORT_B;
            end else if (!from_hub && addr >= sad_pkg::IOAPIC_C_LO && addr <= sad_pkg::IOAPIC_C_HI) begin
                dest = sad_pkg::SAD_DST_PORT_C;
            end else if (!from_hub && addr >= sad_pkg::IOAPIC_D_LO && addr <= sad_pkg::IOAPIC_D_HI) begin
                dest = sad_pkg::SAD_DST_PORT_D;
            end else if (from_hub && is_write && is_dword && addr >= sad_pkg::MSG_LO &&
                         addr <= sad_pkg::MSG_HI) begin
                dest = sad_pkg::SAD_DST_IRQ_MSG;
            end else if ((mb >= b_win[11:0] && mb <= b_win[27:16]) ||
                         (mb >= b_pref[11:0] && mb <= b_pref[27:16])) begin
                dest = sad_pkg::SAD_DST_PORT_B;
            end else if ((mb >= c_win[11:0] && mb <= c_win[27:16]) ||
                         (mb >= c_pref[11:0] && mb <= c_pref[27:16])) begin
                dest = sad_pkg::SAD_DST_PORT_C;
            end else begin
                dest = sad_pkg::SAD_DST_PORT_A;
            end
        end
    end
endmodule : sad_route

/* verif/sad_asserts.sv */
`timescale 1ns/1ps
module sad_asserts (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic req_valid, // Request strobe
    input wire logic [33:0] req_addr, // Address
    input wire logic req_io, // I/O cycle
    input wire logic req_write, // Write
    input wire logic req_from_hub, // From a hub port
    input wire logic req_dword, // Double word
    input wire logic [31:0] req_data, // Write data
    input wire logic route_valid, // Result strobe
    input wire sad_pkg::sad_dest_t route_dest, // Destination
    input wire logic msg_valid, // Message strobe
    input wire logic [31:0] msg_data, // Message data
    input wire logic target_ready // Completion
);
    logic mem;
    assign mem = req_valid && !req_io;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_route_one_cycle: assert property (req_valid |=> route_valid)
        else $error("route strobe late");
    a_msg_completes: assert property (msg_valid |=> target_ready)
        else $error("no target ready");
    a_msg_is_dest: assert property (msg_valid |-> route_valid && route_dest == sad_pkg::SAD_DST_IRQ_MSG)
        else $error("message without message route");
    a_msg_source: assert property (msg_valid |-> $past(req_from_hub && req_dword && req_write))
        else $error("message from wrong access");
    a_msg_payload: assert property (msg_valid |-> msg_data == $past(req_data))
        else $error("message data lost");
    a_low_dram: assert property (mem && req_addr < sad_pkg::VGA_A_LO |=> route_dest == sad_pkg::SAD_DST_DRAM)
        else $error("low memory not dram");
    a_high_dram: assert property (mem && req_addr >= sad_pkg::FOUR_GB |=> route_dest == sad_pkg::SAD_DST_DRAM)
        else $error("high memory not dram");
    a_io_legacy: assert property (req_valid && req_io |=> route_dest == sad_pkg::SAD_DST_PORT_A)
        else $error("io not legacy");
    a_hub_shadow: assert property (mem && req_from_hub && req_addr >= sad_pkg::SHADOW_LO
        && req_addr <= sad_pkg::SHADOW_HI |=> route_dest == sad_pkg::SAD_DST_DRAM)
        else $error("hub shadow not dram");
    c_msg: cover property (msg_valid);
    c_port_b: cover property (route_valid && route_dest == sad_pkg::SAD_DST_PORT_B);
    c_dram: cover property (route_valid && route_dest == sad_pkg::SAD_DST_DRAM);
endmodule : sad_asserts
bind sad_top sad_asserts i_sad_asserts (.aclk, .aresetn, .req_valid, .req_addr, .req_io, .req_write,
    .req_from_hub, .req_dword, .req_data, .route_valid, .route_dest, .msg_valid, .msg_data, .target_ready);

/* verif/sad_req_model.sv */
`timescale 1ns/1ps
// Requester on the processor bus or a hub link
module sad_req_model (
    output logic req_valid, // Request strobe
    output logic [33:0] req_addr, // Address
    output logic [4:0] req_kind, // Hub, write, io, code, dword
    output logic [31:0] req_data, // Write data
    input wire logic aclk // Clock
);
    initial begin
        req_valid = 1'b0;
        req_addr = '0;
        req_kind = '0;
        req_data = '0;
    end
    // Released address and data lines show the inverse so a stale value never decodes
    task automatic send(input logic [33:0] a, input logic [4:0] k, input logic [31:0] d);
        @(posedge aclk);
        req_valid <= 1'b1;
        req_addr <= a;
        req_kind <= k;
        req_data <= d;
        @(posedge aclk);
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_data <= ~d;
    endtask : send
endmodule : sad_req_model

/* verif/sad_top_bench.sv */
`timescale 1ns/1ps
module sad_top_bench;
    logic aclk = 1'b0, aresetn = 1'b0, rv, rva, mv, tr;
    logic [4:0] rk;
    logic [33:0] ra, ma;
    logic [31:0] rd, md, awa, wd, ara, rdata, rdv;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, awr, wrd, bv, arr, rvl;
    logic [1:0] bresp, rresp, bre, rsp;
    sad_pkg::sad_dest_t rdst;
    int num_errors = 0, compares = 0;
    sad_req_model i_sad_req_model (.req_valid(rv), .req_addr(ra), .req_kind(rk), .req_data(rd), .aclk(aclk));
    sad_top i_sad_top (.aclk(aclk), .aresetn(aresetn), .req_valid(rv), .req_addr(ra), .req_io(rk[2]),
        .req_write(rk[3]), .req_from_hub(rk[4]), .req_smm_code(rk[1]), .req_dword(rk[0]), .req_data(rd),
        .route_valid(rva), .route_dest(rdst), .msg_valid(mv), .msg_addr(ma), .msg_data(md), .target_ready(tr),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr));
    initial forever #12.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= 32'(a);
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(negedge aclk); while (!(awr && wrd));
        @(posedge aclk);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(negedge aclk); while (!bv);
        bre = bresp;
        @(posedge aclk);
        br <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        ara <= 32'(a);
        arv <= 1'b1;
        rr <= 1'b1;
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 1'b0;
        do @(negedge aclk); while (!rvl);
        rdv = rdata;
        rsp = rresp;
        @(posedge aclk);
        rr <= 1'b0;
    endtask : rdr
    // Result is checked in the single cycle that the route strobe stands
    task automatic go(input logic [33:0] a, input logic [4:0] k, input sad_pkg::sad_dest_t e);
        i_sad_req_model.send(a, k, 32'h1234_5678);
        @(negedge aclk);
        chk("route_valid", 32'h0000_0001, 32'(rva));
        chk("route_dest", 32'(e), 32'(rdst));
    endtask : go
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        #100_000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(sad_pkg::REG_CTRL);
        chk("ctrl", sad_pkg::CTRL_RESET, rdv);
        go(34'h0_000A_0000, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(34'h0_000F_0000, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(34'h0_0009_0000, 5'h00, sad_pkg::SAD_DST_DRAM);
        wr(sad_pkg::REG_CTRL, 32'h0000_0002);
        go(34'h0_000B_8000, 5'h00, sad_pkg::SAD_DST_PORT_C);
        wr(sad_pkg::REG_CTRL, 32'h0000_000A);
        go(34'h0_000B_0000, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(34'h0_0000_03B4, 5'h04, sad_pkg::SAD_DST_PORT_A);
        wr(sad_pkg::REG_CTRL, 32'h0000_003A);
        go(34'h0_000A_0000, 5'h00, sad_pkg::SAD_DST_DRAM);
        wr(sad_pkg::REG_CTRL, 32'h0000_0012);
        go(34'h0_000B_0000, 5'h02, sad_pkg::SAD_DST_DRAM);
        wr(sad_pkg::REG_SHADOW_LO, 32'h0000_000C);
        go(34'h0_000C_4000, 5'h00, sad_pkg::SAD_DST_DRAM);
        go(34'h0_000C_0000, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(34'h0_000C_0000, 5'h18, sad_pkg::SAD_DST_DRAM);
        wr(sad_pkg::REG_SHADOW_HI, 32'h0000_0001);
        go(34'h0_000E_0000, 5'h00, sad_pkg::SAD_DST_DRAM);
        go(34'h0_000E_0000, 5'h08, sad_pkg::SAD_DST_PORT_A);
        wr(sad_pkg::REG_LOW_TOP, 32'h4000_0000);
        go(sad_pkg::ISA_HOLE_LO, 5'h00, sad_pkg::SAD_DST_DRAM);
        wr(sad_pkg::REG_CTRL, 32'h0000_0040);
        go(sad_pkg::ISA_HOLE_HI, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(sad_pkg::IOAPIC_A_HI, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(sad_pkg::IOAPIC_B_LO, 5'h00, sad_pkg::SAD_DST_PORT_B);
        go(sad_pkg::IOAPIC_C_HI, 5'h00, sad_pkg::SAD_DST_PORT_C);
        go(sad_pkg::IOAPIC_D_HI, 5'h00, sad_pkg::SAD_DST_PORT_D);
        go(sad_pkg::MSG_LO, 5'h19, sad_pkg::SAD_DST_IRQ_MSG);
        chk("msg_data", 32'h1234_5678, md);
        chk("msg_addr", 32'(sad_pkg::MSG_LO), 32'(ma));
        @(negedge aclk);
        chk("target_ready", 32'h0000_0001, 32'(tr));
        wr(sad_pkg::REG_B_WIN, 32'h0800_0800);
        go(34'h0_8000_0000, 5'h00, sad_pkg::SAD_DST_PORT_B);
        wr(sad_pkg::REG_C_PREF, 32'h0A00_0A00);
        go(34'h0_A00F_FFFC, 5'h00, sad_pkg::SAD_DST_PORT_C);
        go(34'h0_9000_0000, 5'h00, sad_pkg::SAD_DST_PORT_A);
        go(34'h3_FFFF_FFF0, 5'h00, sad_pkg::SAD_DST_DRAM);
        wr(sad_pkg::REG_QUERY, 32'h2000_0000);
        rdr(sad_pkg::REG_RESULT);
        chk("result", 32'(sad_pkg::SAD_DST_PORT_B), rdv);
        wr(sad_pkg::REG_RESULT, 32'h0000_0000);
        chk("bresp", 32'h0000_0002, 32'(bre));
        rdr(8'h40);
        chk("rresp", 32'h0000_0002, 32'(rsp));
        give_verdict();
    end
endmodule : sad_top_bench
